// *** dpl_pkg.sv ***
package dpl_pkg;

   // host clock
   localparam int CLK_NS    = 8;

   // pin timing, in ns, as the converter needs them
   localparam int T_SU_NS   = 10;   // data and select settle, selects off
   localparam int T_WR_NS   = 20;   // write strobe low width
   localparam int T_HD_NS   = 10;   // data and select hold after strobe
   localparam int T_LD_NS   = 20;   // load strobe low width
   localparam int T_CLR_NS  = 20;   // clear low width

   // least time in ns to whole clock cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc

   localparam int CNT_W     = 4;
   localparam logic [CNT_W-1:0] SU_CYC  = CNT_W'(ns_to_cyc(T_SU_NS));
   localparam logic [CNT_W-1:0] WR_CYC  = CNT_W'(ns_to_cyc(T_WR_NS));
   localparam logic [CNT_W-1:0] HD_CYC  = CNT_W'(ns_to_cyc(T_HD_NS));
   localparam logic [CNT_W-1:0] LD_CYC  = CNT_W'(ns_to_cyc(T_LD_NS));
   localparam logic [CNT_W-1:0] CLR_CYC = CNT_W'(ns_to_cyc(T_CLR_NS));

   // converters on the shared lines
   localparam int NUM_DEV   = 4;
   localparam int DEV_W     = 2;
   localparam int CODE_W    = 12;
   localparam int BUS_W     = 16;

   // host bus field positions
   localparam int BUF_BIT   = 15;   // wide bus: buffer select
   localparam int GAIN_BIT  = 14;   // wide bus: gain select
   localparam int HB_BUF    = 7;    // high byte: buffer select
   localparam int HB_GAIN   = 6;    // high byte: gain select
   localparam int HB_DATA_W = 4;    // high byte: data bits
   localparam int LB_W      = 8;    // low byte width

   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_WORD   = 8'h04;
   localparam logic [7:0] OFS_CMD    = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;

   // register fields
   localparam int CTRL_BYTE  = 0;   // byte-loaded format
   localparam int CTRL_AUTO  = 1;   // load strobe after every word
   localparam int WORD_GAIN  = 12;
   localparam int WORD_BUF   = 13;
   localparam int WORD_DEV   = 16;
   localparam int CMD_LOAD   = 0;
   localparam int CMD_CLEAR  = 1;
   localparam int ST_BUSY    = 0;
   localparam int ST_CNT     = 16;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // one word for one converter
   typedef struct packed {
      logic [DEV_W-1:0]  dev;
      logic              buf_sel;
      logic              gain_sel;
      logic [CODE_W-1:0] code;
   } dpl_word_t;

   // pins towards the converters
   typedef struct packed {
      logic [NUM_DEV-1:0] cs_n;
      logic               wr_n;
      logic               hbs;
      logic               load_n;
      logic               clr_n;
      logic [BUS_W-1:0]   db;
   } dpl_pins_t;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_SETUP  = 3'b001,
      S_STROBE = 3'b010,
      S_HOLD   = 3'b011,
      S_LOAD   = 3'b100,
      S_CLR    = 3'b101
   } dpl_state_t;

endpackage : dpl_pkg

// *** dpl_host.sv ***
`timescale 1ns/100ps
module dpl_host
   import dpl_pkg::*;
(
   input  wire logic               CLOCK,
   input  wire logic               RSTN,
   input  wire logic               HSEL,
   input  wire logic [31:0]        HADDR,
   input  wire logic [1:0]         HTRANS,
   input  wire logic               HWRITE,
   input  wire logic [2:0]         HSIZE,
   input  wire logic [31:0]        HWDATA,
   input  wire logic               HREADY,
   output logic      [31:0]        HRDATA,
   output logic                    HREADYOUT,
   output logic                    HRESP,
   output logic      [NUM_DEV-1:0] CS_N,
   output logic                    WR_N,
   output logic                    HIGH_BYTE_SELECT,
   output logic                    LOAD_STROBE_N,
   output logic                    CLEAR_N,
   output logic      [BUS_W-1:0]   DATA_BUS
);

   // bus side state
   logic             dph_ff;        // data phase pending
   logic [7:0]       addr_ff;       // latched word offset
   logic             wr_ff;         // latched direction
   logic             hready_ff;     // registered ready
   logic [31:0]      hrdata_ff;     // registered read data
   logic             byte_mode_ff;  // byte-loaded converters
   logic             auto_ld_ff;    // pulse load after each word
   dpl_word_t        word_ff;       // word being sent
   logic             req_word_ff;   // start a word transfer
   logic             req_load_ff;   // start a load pulse
   logic             req_clr_ff;    // start a clear pulse
   logic [15:0]      sent_ff;       // words completed

   // pin side state
   dpl_state_t       state_ff;
   logic [CNT_W-1:0] cnt_ff;        // cycles left in a state
   logic             phase_ff;      // 0 low byte, 1 high byte
   dpl_pins_t        pins_ff;
   dpl_pins_t        nxt_pins;
   logic             nxt_busy;
   logic             can_do;
   logic             take;

   // format the bus for the current beat
   function automatic logic [BUS_W-1:0] fmt(input dpl_word_t w,
                                          input logic bm,
                                          input logic hi);
      logic [BUS_W-1:0] d;
      d = '0;
      if (!bm) begin
         d[CODE_W-1:0] = w.code;
         d[BUF_BIT]    = w.buf_sel;
         d[GAIN_BIT]   = w.gain_sel;
      end else if (!hi) begin
         // bits 6 and 7 are code here; the converter parks them
         d[LB_W-1:0]   = w.code[LB_W-1:0];
      end else begin
         d[HB_DATA_W-1:0] = w.code[CODE_W-1:LB_W];
         d[HB_GAIN]       = w.gain_sel;
         d[HB_BUF]        = w.buf_sel;
      end
      return d;
   endfunction : fmt

   // a command needs the pin engine idle; stall the bus otherwise
   assign nxt_busy = (state_ff != S_IDLE) || req_word_ff ||
                     req_load_ff || req_clr_ff;
   assign can_do   = !(wr_ff && (addr_ff == OFS_WORD ||
                       addr_ff == OFS_CMD) && nxt_busy);
   assign take     = HSEL && HTRANS[1] && HREADY;

   // address phase capture and ready generation, one wait state minimum
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         dph_ff    <= 1'b0;
         addr_ff   <= '0;
         wr_ff     <= 1'b0;
         hready_ff <= 1'b1;
      end else if (take && hready_ff) begin
         dph_ff    <= 1'b1;
         addr_ff   <= {HADDR[7:2], 2'b00};
         wr_ff     <= HWRITE;
         hready_ff <= 1'b0;
      end else if (dph_ff && can_do) begin
         dph_ff    <= 1'b0;
         hready_ff <= 1'b1;
      end
   end

   // read data, registered when the data phase completes
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         hrdata_ff <= '0;
      end else if (dph_ff && !wr_ff) begin
         unique case (addr_ff)
            OFS_CTRL:   hrdata_ff <= 32'({auto_ld_ff, byte_mode_ff});
            OFS_WORD:   hrdata_ff <= 32'(word_ff)
                                     << 0;
            OFS_STATUS: hrdata_ff <= {sent_ff, 15'h0000, nxt_busy};
            default:    hrdata_ff <= '0;  // command and unmapped
         endcase
      end
   end

   // software registers and requests to the pin engine
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         byte_mode_ff <= 1'b0;
         auto_ld_ff   <= 1'b0;
         word_ff      <= dpl_word_t'(RST_WORD[$bits(dpl_word_t)-1:0]);
         req_word_ff  <= 1'b0;
         req_load_ff  <= 1'b0;
         req_clr_ff   <= 1'b0;
      end else begin
         req_word_ff <= 1'b0;
         req_load_ff <= 1'b0;
         req_clr_ff  <= 1'b0;
         if (dph_ff && wr_ff && can_do) begin
            unique case (addr_ff)
               OFS_CTRL: begin
                  byte_mode_ff <= HWDATA[CTRL_BYTE];
                  auto_ld_ff   <= HWDATA[CTRL_AUTO];
               end
               OFS_WORD: begin
                  word_ff.code     <= HWDATA[CODE_W-1:0];
                  word_ff.gain_sel <= HWDATA[WORD_GAIN];
                  word_ff.buf_sel  <= HWDATA[WORD_BUF];
                  word_ff.dev      <= HWDATA[WORD_DEV +: DEV_W];
                  req_word_ff      <= 1'b1;
               end
               OFS_CMD: begin
                  req_load_ff <= HWDATA[CMD_LOAD];
                  req_clr_ff  <= HWDATA[CMD_CLEAR];
               end
               default: ;  // unmapped writes are dropped
            endcase
         end
      end
   end

   // pin engine: state, counter and beat
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         state_ff <= S_IDLE;
         cnt_ff   <= '0;
         phase_ff <= 1'b0;
      end else begin
         if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
         unique case (state_ff)
            S_IDLE: begin
               phase_ff <= 1'b0;
               if (req_clr_ff) begin
                  state_ff <= S_CLR;
                  cnt_ff   <= CLR_CYC - 1'b1;
               end else if (req_load_ff) begin
                  state_ff <= S_LOAD;
                  cnt_ff   <= LD_CYC - 1'b1;
               end else if (req_word_ff) begin
                  // full count: the bus only starts moving in setup
                  state_ff <= S_SETUP;
                  cnt_ff   <= SU_CYC;
               end
            end
            S_SETUP: if (cnt_ff == '0) begin
               state_ff <= S_STROBE;
               cnt_ff   <= WR_CYC - 1'b1;
            end
            S_STROBE: if (cnt_ff == '0) begin
               state_ff <= S_HOLD;
               cnt_ff   <= HD_CYC - 1'b1;
            end
            S_HOLD: if (cnt_ff == '0) begin
               if (byte_mode_ff && !phase_ff) begin
                  phase_ff <= 1'b1;
                  state_ff <= S_SETUP;
                  cnt_ff   <= SU_CYC;
               end else if (auto_ld_ff) begin
                  // load only once the whole word is in place
                  // no idle cycle leads in here, so the pulse needs all
                  state_ff <= S_LOAD;
                  cnt_ff   <= LD_CYC;
               end else begin
                  state_ff <= S_IDLE;
               end
            end
            S_LOAD, S_CLR: if (cnt_ff == '0) begin
               state_ff <= S_IDLE;
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   // pin levels for the next cycle
   always_comb begin
      nxt_pins        = pins_ff;
      nxt_pins.cs_n   = '1;
      nxt_pins.wr_n   = 1'b1;
      nxt_pins.load_n = 1'b1;
      nxt_pins.clr_n  = 1'b1;
      unique case (state_ff)
         S_SETUP: begin
            // selects stay off while bus and byte select move
            nxt_pins.db  = fmt(word_ff, byte_mode_ff, phase_ff);
            nxt_pins.hbs = byte_mode_ff && phase_ff;
            if (cnt_ff == '0) begin
               nxt_pins.cs_n[word_ff.dev] = 1'b0;
               nxt_pins.wr_n              = 1'b0;
            end
         end
         S_STROBE: begin
            nxt_pins.cs_n[word_ff.dev] = 1'b0;
            nxt_pins.wr_n              = (cnt_ff == '0);
         end
         S_HOLD: begin
            // select held past the write rise so the latch is clean
            nxt_pins.cs_n[word_ff.dev] = (cnt_ff == '0);
         end
         S_LOAD: nxt_pins.load_n = (cnt_ff == '0);
         S_CLR:  nxt_pins.clr_n  = (cnt_ff == '0);
         default: begin
            if (req_load_ff && !req_clr_ff) begin
               nxt_pins.load_n = 1'b0;
            end
            if (req_clr_ff) begin
               nxt_pins.clr_n = 1'b0;
            end
         end
      endcase
   end

   // pin flops; after reset nothing is driven active
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         pins_ff <= '{cs_n: '1, wr_n: 1'b1, hbs: 1'b0,
                      load_n: 1'b1, clr_n: 1'b1, db: '0};
      end else begin
         pins_ff <= nxt_pins;
      end
   end

   // completed words, for software progress checks
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         sent_ff <= '0;
      end else if (state_ff == S_HOLD && cnt_ff == '0 &&
                   !(byte_mode_ff && !phase_ff)) begin
         sent_ff <= sent_ff + 16'h0001;
      end
   end

   assign HRDATA           = hrdata_ff;
   assign HREADYOUT        = hready_ff;
   assign HRESP            = 1'b0;
   assign CS_N             = pins_ff.cs_n;
   assign WR_N             = pins_ff.wr_n;
   assign HIGH_BYTE_SELECT = pins_ff.hbs;
   assign LOAD_STROBE_N    = pins_ff.load_n;
   assign CLEAR_N          = pins_ff.clr_n;
   assign DATA_BUS         = pins_ff.db;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   one_select_a: assert property ($onehot0(~CS_N))
      else $error("more than one converter selected");
   write_in_select_a: assert property (!WR_N |-> !(&CS_N))
      else $error("write strobe without a select");
   quiet_select_a: assert property
      (($changed(DATA_BUS) || $changed(HIGH_BYTE_SELECT)) |-> &CS_N)
      else $error("bus changed while a converter was selected");
   strobe_width_a: assert property
      ($fell(WR_N) |-> !WR_N[*3] ##1 (WR_N && !(&CS_N)))
      else $error("write strobe width or select hold wrong");
   byte_order_a: assert property
      ($rose(WR_N) && byte_mode_ff && !HIGH_BYTE_SELECT
       |-> ##[1:8] ($fell(WR_N) && HIGH_BYTE_SELECT))
      else $error("high byte did not follow the low byte");
   wide_format_a: assert property
      (!WR_N && !byte_mode_ff |-> DATA_BUS[BUF_BIT] == word_ff.buf_sel
       && DATA_BUS[GAIN_BIT] == word_ff.gain_sel && !HIGH_BYTE_SELECT)
      else $error("wide bus selects misplaced");
   high_format_a: assert property
      (!WR_N && HIGH_BYTE_SELECT |-> DATA_BUS[HB_BUF] == word_ff.buf_sel
       && DATA_BUS[HB_GAIN] == word_ff.gain_sel
       && DATA_BUS[HB_DATA_W-1:0] == word_ff.code[CODE_W-1:LB_W])
      else $error("high byte layout wrong");
   load_pulse_a: assert property
      ($fell(LOAD_STROBE_N) |-> (!LOAD_STROBE_N && &CS_N)[*3]
       ##1 LOAD_STROBE_N)
      else $error("load strobe width wrong or overlaps a select");
   clear_pulse_a: assert property
      ($fell(CLEAR_N) |-> !CLEAR_N[*3] ##1 CLEAR_N)
      else $error("clear pulse width wrong");
   read_answer_a: assert property
      (take && HREADYOUT && !HWRITE |-> ##1 !HREADYOUT ##1 HREADYOUT)
      else $error("register read not answered in two cycles");

   byte_word_c: cover property
      ($fell(WR_N) && !HIGH_BYTE_SELECT ##[1:8] $fell(WR_N)
       && HIGH_BYTE_SELECT);
   auto_load_c: cover property ($rose(WR_N) ##[1:4] $fell(LOAD_STROBE_N));
   clear_c:     cover property ($fell(CLEAR_N));
   stall_c:     cover property (dph_ff && !can_do);

endmodule : dpl_host

// *** dpl_conv_model.sv ***
`timescale 1ns/100ps
// behavioural bank of converters on the shared host lines
module dpl_conv_model
   import dpl_pkg::*;
(
   input  wire logic                            byte_mode, // byte-loaded parts
   input  wire logic [NUM_DEV-1:0]              cs_n,
   input  wire logic                            wr_n,
   input  wire logic                            hbs,
   input  wire logic                            load_n,
   input  wire logic                            clr_n,
   input  wire logic [BUS_W-1:0]                db,
   output logic      [NUM_DEV-1:0][CODE_W+1:0]  act        // {buf,gain,code}
);
   logic [NUM_DEV-1:0][CODE_W+1:0] inp;                    // input stage

   // power-up: both stages zero
   initial begin
      inp = '0;
      act = '0;
   end

   // input stage: latched on write rise, cleared at once by clear low
   always @(posedge wr_n or negedge clr_n) begin
      if (!clr_n) begin
         inp <= '0;
      end else begin
         for (int d = 0; d < NUM_DEV; d++) begin
            if (!cs_n[d]) begin
               if (!byte_mode) begin
                  // selects travel like data bits
                  inp[d] <= {db[BUF_BIT], db[GAIN_BIT], db[CODE_W-1:0]};
               end else if (!hbs) begin
                  // low byte also hits the select holders, overwritten later
                  inp[d][LB_W-1:0]     <= db[LB_W-1:0];
                  inp[d][CODE_W+1:CODE_W] <= {db[HB_BUF], db[HB_GAIN]};
               end else begin
                  // only four data bits from the high byte
                  inp[d][CODE_W-1:LB_W] <= db[HB_DATA_W-1:0];
                  inp[d][CODE_W+1:CODE_W] <= {db[HB_BUF], db[HB_GAIN]};
               end
            end
         end
      end
   end

   // active stage: zero while clear is low, else transparent while load is low, else held
   always @* begin
      if (!clr_n) begin
         act = '0;
      end else if (!load_n) begin
         act = inp;
      end
   end
endmodule : dpl_conv_model

// *** test_dpl_host.sv ***
`timescale 1ns/100ps
module test_dpl_host
   import dpl_pkg::*;
;
   logic                           clock, rstn, hsel, hwrite, hresp, hreadyout;
   logic [31:0]                    haddr, hwdata, hrdata;
   logic [1:0]                     htrans;
   logic [NUM_DEV-1:0]             cs_n;
   logic                           wr_n, hbs, load_n, clr_n, mode_byte;
   logic                           auto_on, exp_hb;
   logic [BUS_W-1:0]               db;
   logic [BUS_W:0]                 prev_pins;
   logic [NUM_DEV-1:0][CODE_W+1:0] act;
   logic [CODE_W+1:0]              exp_inp [NUM_DEV];
   logic [CODE_W+1:0]              exp_act [NUM_DEV];
   int                             err_count, samples_checked, cycles, words;
   localparam int LIMIT = 6000;    // generous over the sequence below

   dpl_host i_dut (.CLOCK(clock), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .CS_N(cs_n), .WR_N(wr_n), .HIGH_BYTE_SELECT(hbs),
      .LOAD_STROBE_N(load_n), .CLEAR_N(clr_n), .DATA_BUS(db));
   dpl_conv_model i_conv (.byte_mode(mode_byte), .cs_n(cs_n), .wr_n(wr_n),
      .hbs(hbs), .load_n(load_n), .clr_n(clr_n), .db(db), .act(act));

   initial begin
      clock = 1'b0;
      forever #(CLK_NS / 2) clock = ~clock;
   end

   task automatic results;
      if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_reg

   task automatic check_dac(input logic [CODE_W+1:0] got,
                            input logic [CODE_W+1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_dac

   // one AHB single transfer; address held until the slave is ready
   task automatic ahb_xfer(input logic w, input logic [7:0] a,
                           input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      q = hrdata;
   endtask : ahb_xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb_xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      ahb_xfer(1'b0, a, 32'h0000_0000, q);
      check_reg(q, exp);
      check_reg({31'h0, hresp}, 32'h0000_0000);
   endtask : rd_chk

   // poll busy; the timeout cuts a hang short
   task automatic wait_idle;
      logic [31:0] s;
      s = 32'h0000_0001;
      while (s[ST_BUSY] !== 1'b0) ahb_xfer(1'b0, OFS_STATUS, 32'h0, s);
   endtask : wait_idle

   task automatic set_ctrl(input logic bm, input logic au);
      wr(OFS_CTRL, {30'h0, au, bm});
      mode_byte = bm;
      auto_on = au;
      exp_hb = 1'b0;
   endtask : set_ctrl

   // one word to one converter, expectations follow it
   task automatic put(input logic [1:0] dev, input logic [11:0] code,
                      input logic g, input logic b);
      logic [31:0] w;
      w = '0;
      w[WORD_DEV +: DEV_W] = dev;
      w[WORD_BUF] = b;
      w[WORD_GAIN] = g;
      w[CODE_W-1:0] = code;
      wr(OFS_WORD, w);
      wait_idle();
      words++;
      exp_inp[dev] = {b, g, code};
      if (auto_on) exp_act = exp_inp;
   endtask : put

   task automatic cmd(input logic [1:0] c);
      wr(OFS_CMD, {30'h0, c});
      wait_idle();
      if (c[CMD_CLEAR]) begin
         exp_inp = '{default: '0};
         exp_act = '{default: '0};
      end else if (c[CMD_LOAD]) begin
         exp_act = exp_inp;
      end
   endtask : cmd

   task automatic check_all;
      for (int d = 0; d < NUM_DEV; d++)
         check_dac(act[d], exp_act[d]);
   endtask : check_all

   // selects must be off whenever the bus or byte select moves
   always @(posedge clock) begin
      if ({hbs, db} !== prev_pins)
         check_reg({28'h0, cs_n}, 32'h0000_000F);
      prev_pins <= {hbs, db};
   end

   // byte mode: low byte strobe first, then high byte
   always @(posedge wr_n) begin
      if (mode_byte === 1'b1) begin
         check_reg({31'h0, hbs}, {31'h0, exp_hb});
         exp_hb = ~exp_hb;
      end
   end

   // hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_count++;
         results();
      end
   end

   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      {rstn, mode_byte, auto_on, exp_hb} = '0;
      {err_count, samples_checked, cycles, words} = '0;
      exp_inp = '{default: '0};
      exp_act = '{default: '0};
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      check_all();
      rd_chk(OFS_CTRL, 32'h0000_0000);
      rd_chk(OFS_WORD, RST_WORD);
      wr(8'h10, 32'hFFFF_FFFF);
      rd_chk(8'h10, 32'h0000_0000);
      set_ctrl(1'b0, 1'b0);
      put(2'd1, 12'hABC, 1'b1, 1'b0);
      check_all();
      cmd(2'b01);
      check_all();
      put(2'd0, 12'h123, 1'b0, 1'b1);
      put(2'd2, 12'hFFF, 1'b1, 1'b1);
      put(2'd3, 12'h000, 1'b1, 1'b0);
      check_all();
      cmd(2'b01);
      check_all();
      set_ctrl(1'b1, 1'b0);
      put(2'd3, 12'h5A7, 1'b1, 1'b0);
      put(2'd2, 12'hFFF, 1'b0, 1'b0);
      check_all();
      cmd(2'b01);
      check_all();
      rd_chk(OFS_WORD, 32'h0000_8FFF);
      set_ctrl(1'b1, 1'b1);
      put(2'd0, 12'h3C5, 1'b0, 1'b1);
      check_all();
      set_ctrl(1'b0, 1'b1);
      put(2'd1, 12'h800, 1'b1, 1'b1);
      check_all();
      rd_chk(OFS_STATUS, {16'(words), 16'h0000});
      cmd(2'b11);
      check_all();
      cmd(2'b01);
      check_all();
      results();
   end
endmodule : test_dpl_host
